//--- rtl/scer_pkg.sv
// Package of constants for the completion error report controller.
package scer_pkg;
  // ==========================================================================
  // Error flag bit positions
  localparam int ERR_W          = 7;
  localparam int ERR_CTO_REC    = 0;
  localparam int ERR_CTO_NOREC  = 1;
  localparam int ERR_CA         = 2;
  localparam int ERR_UNEXP_CPL  = 3;
  localparam int ERR_UR_POSTED  = 4;
  localparam int ERR_UR_NP      = 5;
  localparam int ERR_LOG_HDR    = 6;
  // ==========================================================================
  // Widths and reset values
  localparam int HDR_W          = 128;
  localparam int VF_OFS_W       = 11;
  localparam int PF_NUM_DEF     = 4;
  localparam int PF_IDX_W_DEF   = 2;
  localparam int VF_COUNT_DEF   = 2048;
  localparam logic [ERR_W-1:0] ERR_RST = 7'h00;
  // ==========================================================================
  // Request state machine
  typedef enum logic [1:0] {SCER_IDLE, SCER_WAIT, SCER_DROP} scer_state_type;
endpackage : scer_pkg

//--- rtl/scer_if.sv
// Interface carrying error report pulses between the controller and its helper.
`timescale 1ns/1ps
interface scer_err_if
  import scer_pkg::*;
#(
  parameter int PF_IDX_W = PF_IDX_W_DEF
);
  logic                ur_posted;
  logic                ur_np;
  logic                log_hdr;
  logic                is_vf;
  logic [PF_IDX_W-1:0] pf_idx;
  logic [VF_OFS_W-1:0] vf_ofs;
  logic [HDR_W-1:0]    hdr;
  logic                fire;
  modport src (output ur_posted, ur_np, log_hdr, is_vf, pf_idx, vf_ofs, hdr, fire);
  modport dst (input  ur_posted, ur_np, log_hdr, is_vf, pf_idx, vf_ofs, hdr, fire);
endinterface : scer_err_if

//--- rtl/scer_err_pulse.sv
// Error flag pulse generator: turns a request into one-cycle flag pulses.
`timescale 1ns/1ps
module scer_err_pulse
  import scer_pkg::*;
#(
  parameter int PF_IDX_W = PF_IDX_W_DEF
)(
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                rst,
  // Request
  scer_err_if.dst                  req,
  // Outputs toward the bridge
  output logic [ERR_W-1:0]         err_flags_r,
  output logic [PF_IDX_W-1:0]      err_pf_index_r,
  output logic                     err_is_virtual_fn_r,
  output logic [VF_OFS_W-1:0]      err_vf_offset_r,
  output logic [HDR_W-1:0]         err_hdr_r
);
  // ==========================================================================
  // Flag pulse; the request is one cycle, so each flag is one cycle.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      err_flags_r <= ERR_RST;
    end else begin
      err_flags_r <= '0;
      if (req.fire) begin
        err_flags_r[ERR_UR_POSTED] <= req.ur_posted;
        err_flags_r[ERR_UR_NP]     <= req.ur_np;
        err_flags_r[ERR_LOG_HDR]   <= req.log_hdr & (req.ur_posted | req.ur_np);
      end
    end
  end
  // ==========================================================================
  // Function identity and header, loaded with the flags and held until the next report.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      err_pf_index_r      <= '0;
      err_is_virtual_fn_r <= 1'b0;
      err_vf_offset_r     <= '0;
      err_hdr_r           <= '0;
    end else if (req.fire) begin
      err_pf_index_r      <= req.pf_idx;
      err_is_virtual_fn_r <= req.is_vf;
      err_vf_offset_r     <= req.is_vf ? req.vf_ofs : '0;
      err_hdr_r           <= req.hdr;
    end
  end
  // Back to back reports are legal, so each flag cycle must be owed to its own request.
  a_flag_one_cycle: assert property (@(posedge mclk) disable iff (rst)
    err_flags_r[ERR_UR_POSTED] |-> ($past(req.fire) && $past(req.ur_posted)))
    else $error("Posted error flag without its own request.");
  a_np_one_cycle: assert property (@(posedge mclk) disable iff (rst)
    err_flags_r[ERR_UR_NP] |-> ($past(req.fire) && $past(req.ur_np)))
    else $error("Non-posted error flag without its own request.");
  a_log_with_err: assert property (@(posedge mclk) disable iff (rst)
    err_flags_r[ERR_LOG_HDR] |-> (err_flags_r[ERR_UR_POSTED] | err_flags_r[ERR_UR_NP]))
    else $error("Header log flag without an error flag.");
endmodule : scer_err_pulse

//--- rtl/scer_pend_hs.sv
// Request and acknowledge handshake for VF completion-pending updates.
`timescale 1ns/1ps
module scer_pend_hs
  import scer_pkg::*;
#(
  parameter int PF_IDX_W = PF_IDX_W_DEF
)(
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                rst,
  // User side
  input  wire logic                upd_valid,
  input  wire logic                upd_value,
  input  wire logic [PF_IDX_W-1:0] upd_pf,
  input  wire logic [VF_OFS_W-1:0] upd_vf,
  output logic                     upd_ready,
  // Bridge side
  input  wire logic                ack_s,
  output logic                     vf_pending_change_req_r,
  output logic                     vf_pending_value_r,
  output logic [PF_IDX_W-1:0]      vf_pending_pf_index_r,
  output logic [VF_OFS_W-1:0]      vf_pending_vf_offset_r,
  output logic                     done
);
  scer_state_type state_r;
  // ==========================================================================
  // The drop state gives one idle cycle so the bridge never sees
  // two updates merged into one long request.
  assign upd_ready = (state_r == SCER_IDLE);
  assign done      = (state_r == SCER_WAIT) && ack_s;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r                 <= SCER_IDLE;
      vf_pending_change_req_r <= 1'b0;
      vf_pending_value_r      <= 1'b0;
      vf_pending_pf_index_r   <= '0;
      vf_pending_vf_offset_r  <= '0;
    end else begin
      case (state_r)
        SCER_IDLE: begin
          if (upd_valid) begin
            vf_pending_change_req_r <= 1'b1;
            vf_pending_value_r      <= upd_value;
            vf_pending_pf_index_r   <= upd_pf;
            vf_pending_vf_offset_r  <= upd_vf;
            state_r                 <= SCER_WAIT;
          end
        end
        SCER_WAIT: begin
          if (ack_s) begin
            vf_pending_change_req_r <= 1'b0;
            state_r                 <= SCER_DROP;
          end
        end
        SCER_DROP: begin
          state_r <= SCER_IDLE;
        end
        default: begin
          state_r <= SCER_IDLE;
        end
      endcase
    end
  end
  a_req_held: assert property (@(posedge mclk) disable iff (rst)
    (vf_pending_change_req_r && !ack_s) |=> vf_pending_change_req_r)
    else $error("Change request dropped before acknowledge.");
  a_req_drop: assert property (@(posedge mclk) disable iff (rst)
    (vf_pending_change_req_r && ack_s) |=> !vf_pending_change_req_r ##1 !vf_pending_change_req_r)
    else $error("Change request not dropped after acknowledge.");
  a_data_stable: assert property (@(posedge mclk) disable iff (rst)
    (vf_pending_change_req_r && $past(vf_pending_change_req_r)) |->
      $stable({vf_pending_value_r, vf_pending_pf_index_r, vf_pending_vf_offset_r}))
    else $error("Pending data changed while request high.");
endmodule : scer_pend_hs

//--- rtl/scer_ctrl.sv
// Application-side controller reporting completion errors and pending status.
`timescale 1ns/1ps
module scer_ctrl
  import scer_pkg::*;
#(
  parameter int PF_NUM   = PF_NUM_DEF,
  parameter int PF_IDX_W = PF_IDX_W_DEF,
  parameter int VF_COUNT = VF_COUNT_DEF
)(
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                rst,
  // User error report
  input  wire logic                rep_valid,
  input  wire logic                rep_ur_posted,
  input  wire logic                rep_ur_np,
  input  wire logic                rep_log_hdr,
  input  wire logic                rep_is_vf,
  input  wire logic [PF_IDX_W-1:0] rep_pf,
  input  wire logic [VF_OFS_W-1:0] rep_vf,
  input  wire logic [HDR_W-1:0]    rep_hdr,
  output logic                     rep_reject_r,
  // User per-PF outstanding requests
  input  wire logic [PF_NUM-1:0]   np_issue,
  input  wire logic [PF_NUM-1:0]   np_complete,
  // User VF pending update
  input  wire logic                upd_valid,
  input  wire logic                upd_value,
  input  wire logic [PF_IDX_W-1:0] upd_pf,
  input  wire logic [VF_OFS_W-1:0] upd_vf,
  output logic                     upd_ready_r,
  output logic                     upd_done_r,
  // Bridge side
  output logic [ERR_W-1:0]         err_flags_r,
  output logic [PF_IDX_W-1:0]      err_pf_index_r,
  output logic                     err_is_virtual_fn_r,
  output logic [VF_OFS_W-1:0]      err_vf_offset_r,
  output logic [HDR_W-1:0]         err_hdr_r,
  output logic [PF_NUM-1:0]        pf_completion_outstanding_r,
  output logic                     vf_pending_change_req_r,
  output logic                     vf_pending_value_r,
  output logic [PF_IDX_W-1:0]      vf_pending_pf_index_r,
  output logic [VF_OFS_W-1:0]      vf_pending_vf_offset_r,
  input  wire logic                vf_pending_change_ack
);
  localparam int CNT_W = 8;
  localparam logic [VF_OFS_W-1:0] VF_MAX = VF_OFS_W'(VF_COUNT - 1);
  // ==========================================================================
  // Acknowledge comes from the bridge on the same clock, so no synchroniser.
  scer_err_if #(.PF_IDX_W(PF_IDX_W)) eif ();
  logic rep_ok;
  logic upd_ready;
  logic upd_done;
  // Offsets outside the attached VF set are refused rather than reported.
  assign rep_ok = !rep_is_vf || (rep_vf <= VF_MAX);
  assign eif.fire      = rep_valid && rep_ok && (rep_ur_posted || rep_ur_np);
  assign eif.ur_posted = rep_ur_posted;
  assign eif.ur_np     = rep_ur_np;
  assign eif.log_hdr   = rep_log_hdr;
  assign eif.is_vf     = rep_is_vf;
  assign eif.pf_idx    = rep_pf;
  assign eif.vf_ofs    = rep_vf;
  assign eif.hdr       = rep_hdr;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rep_reject_r <= 1'b0;
    end else begin
      rep_reject_r <= rep_valid && !rep_ok;
    end
  end
  scer_err_pulse #(.PF_IDX_W(PF_IDX_W)) u_err (
    .mclk                (mclk),
    .rst                 (rst),
    .req                 (eif),
    .err_flags_r         (err_flags_r),
    .err_pf_index_r      (err_pf_index_r),
    .err_is_virtual_fn_r (err_is_virtual_fn_r),
    .err_vf_offset_r     (err_vf_offset_r),
    .err_hdr_r           (err_hdr_r)
  );
  // ==========================================================================
  // Per-PF outstanding counters. Counter saturates; the user must keep
  // fewer than 256 non-posted requests open per PF.
  genvar gi;
  generate
    for (gi = 0; gi < PF_NUM; gi++) begin : g_pf
      logic [CNT_W-1:0] cnt_r;
      logic [CNT_W-1:0] cnt_nxt;
      always_comb begin
        cnt_nxt = cnt_r;
        if (np_issue[gi] && !np_complete[gi] && cnt_r != '1) begin
          cnt_nxt = cnt_r + CNT_W'(1);
        end else if (!np_issue[gi] && np_complete[gi] && cnt_r != '0) begin
          cnt_nxt = cnt_r - CNT_W'(1);
        end
      end
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          cnt_r                           <= '0;
          pf_completion_outstanding_r[gi] <= 1'b0;
        end else begin
          cnt_r                           <= cnt_nxt;
          pf_completion_outstanding_r[gi] <= (cnt_nxt != '0);
        end
      end
      a_pend_bit: assert property (@(posedge mclk) disable iff (rst)
        (np_issue[gi] && !np_complete[gi]) |=> pf_completion_outstanding_r[gi])
        else $error("Outstanding flag not set after a new request.");
    end
  endgenerate
  // ==========================================================================
  // VF pending change handshake.
  scer_pend_hs #(.PF_IDX_W(PF_IDX_W)) u_hs (
    .mclk                    (mclk),
    .rst                     (rst),
    .upd_valid               (upd_valid),
    .upd_value               (upd_value),
    .upd_pf                  (upd_pf),
    .upd_vf                  (upd_vf),
    .upd_ready               (upd_ready),
    .ack_s                   (vf_pending_change_ack),
    .vf_pending_change_req_r (vf_pending_change_req_r),
    .vf_pending_value_r      (vf_pending_value_r),
    .vf_pending_pf_index_r   (vf_pending_pf_index_r),
    .vf_pending_vf_offset_r  (vf_pending_vf_offset_r),
    .done                    (upd_done)
  );
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      upd_ready_r <= 1'b0;
      upd_done_r  <= 1'b0;
    end else begin
      upd_ready_r <= upd_ready && !upd_valid;
      upd_done_r  <= upd_done;
    end
  end
  a_done_pulse: assert property (@(posedge mclk) disable iff (rst)
    upd_done_r |-> ($past(vf_pending_change_ack) && !vf_pending_change_req_r) ##1 !upd_done_r)
    else $error("Update done not a single pulse after acknowledge.");
  a_vf_range: assert property (@(posedge mclk) disable iff (rst)
    err_is_virtual_fn_r |-> err_vf_offset_r <= VF_MAX)
    else $error("Reported VF offset out of range.");
endmodule : scer_ctrl

//--- verif/scer_bridge_model.sv
// Behavioural bridge model that records error reports and answers VF pending updates.
`timescale 1ns/1ps
module scer_bridge_model
  import scer_pkg::*;
#(
  parameter int PF_IDX_W = PF_IDX_W_DEF
)(
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                rst,
  // Error report
  input  wire logic [ERR_W-1:0]    err_flags,
  input  wire logic [HDR_W-1:0]    err_hdr,
  // VF pending handshake
  input  wire logic                req,
  input  wire logic                value,
  input  wire logic [PF_IDX_W-1:0] pf,
  input  wire logic [VF_OFS_W-1:0] vf,
  input  wire logic [7:0]          ack_dly,
  output logic                     ack
);
  // ==========================================================================
  // Error status
  int               n_ur_posted;
  int               n_ur_np;
  logic [HDR_W-1:0] logged_hdr;
  logic             pend_tab [2**PF_IDX_W][2048];
  logic [7:0]       wait_cnt;
  logic             acked;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      n_ur_posted <= 0;
      n_ur_np     <= 0;
      logged_hdr  <= 128'h0;
    end else begin
      if (err_flags[ERR_UR_POSTED]) n_ur_posted <= n_ur_posted + 1;
      if (err_flags[ERR_UR_NP]) n_ur_np <= n_ur_np + 1;
      if (err_flags[ERR_LOG_HDR]) logged_hdr <= err_hdr;
    end
  end

  // ==========================================================================
  // Pending table and acknowledge
  // The table is written on the acknowledge cycle, so data dropped early is caught.
  always_ff @(posedge mclk) begin
    if (ack && req) pend_tab[pf][vf] <= value;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack      <= 1'b0;
      acked    <= 1'b0;
      wait_cnt <= 8'h00;
    end else begin
      ack <= 1'b0;
      if (!req) begin
        acked    <= 1'b0;
        wait_cnt <= 8'h00;
      end else if (!acked && wait_cnt >= ack_dly) begin
        ack   <= 1'b1;
        acked <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 8'h01;
      end
    end
  end
endmodule : scer_bridge_model

//--- verif/tb_scer_ctrl.sv
// Testbench for the completion error report controller.
`timescale 1ns/1ps
module tb_scer_ctrl
  import scer_pkg::*;
;
  localparam int VF_CNT = 8;
  // ==========================================================================
  // Signals
  logic                mclk = 1'b0;
  logic                rst = 1'b1;
  logic                rep_valid = 1'b0, rep_p = 1'b0, rep_np = 1'b0, rep_lg = 1'b0;
  logic                rep_vfa = 1'b0, upd_valid = 1'b0, upd_value = 1'b0;
  logic                rej, done, req, pend_val, ack, err_isvf, rdy;
  logic [1:0]          rep_pf = 2'h0, upd_pf = 2'h0, pend_pf, err_pf;
  logic [VF_OFS_W-1:0] rep_vf = 11'h000, upd_vf = 11'h000, pend_vf, err_vf;
  logic [HDR_W-1:0]    rep_hdr = 128'h0, err_hdr;
  logic [3:0]          np_issue = 4'h0, np_complete = 4'h0, outstanding;
  logic [ERR_W-1:0]    flags;
  logic [7:0]          ack_dly = 8'h00;
  int                  n_errors = 0, checked = 0;

  scer_ctrl #(.PF_NUM(4), .PF_IDX_W(2), .VF_COUNT(VF_CNT)) u_dut (
    .mclk(mclk), .rst(rst), .rep_valid(rep_valid), .rep_ur_posted(rep_p), .rep_ur_np(rep_np),
    .rep_log_hdr(rep_lg), .rep_is_vf(rep_vfa), .rep_pf(rep_pf), .rep_vf(rep_vf),
    .rep_hdr(rep_hdr), .rep_reject_r(rej), .np_issue(np_issue), .np_complete(np_complete),
    .upd_valid(upd_valid), .upd_value(upd_value), .upd_pf(upd_pf), .upd_vf(upd_vf),
    .upd_ready_r(rdy), .upd_done_r(done), .err_flags_r(flags), .err_pf_index_r(err_pf),
    .err_is_virtual_fn_r(err_isvf), .err_vf_offset_r(err_vf), .err_hdr_r(err_hdr),
    .pf_completion_outstanding_r(outstanding), .vf_pending_change_req_r(req),
    .vf_pending_value_r(pend_val), .vf_pending_pf_index_r(pend_pf),
    .vf_pending_vf_offset_r(pend_vf), .vf_pending_change_ack(ack));

  scer_bridge_model #(.PF_IDX_W(2)) u_bridge (
    .mclk(mclk), .rst(rst), .err_flags(flags), .err_hdr(err_hdr), .req(req), .value(pend_val),
    .pf(pend_pf), .vf(pend_vf), .ack_dly(ack_dly), .ack(ack));

  initial begin
    forever #2.5 mclk = ~mclk;
  end

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [HDR_W-1:0] seen, input logic [HDR_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out();
    if (n_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  task automatic report(input logic p, np, lg, vfa, input logic [1:0] pf,
                        input logic [VF_OFS_W-1:0] vf);
    logic             bad;
    logic             ok;
    logic [HDR_W-1:0] hdr;
    bad = vfa && (vf > VF_CNT - 1);
    ok  = (p || np) && !bad;
    hdr = {8{3'h5, pf, vf}};
    @(posedge mclk);
    rep_valid <= 1'b1;
    rep_p     <= p;
    rep_np    <= np;
    rep_lg    <= lg;
    rep_vfa   <= vfa;
    rep_pf    <= pf;
    rep_vf    <= vf;
    rep_hdr   <= hdr;
    @(posedge mclk);
    rep_valid <= 1'b0;
    #1;
    chk(flags, ok ? {lg, np, p, 4'h0} : 7'h00);
    chk(rej, bad);
    if (ok) begin
      chk({err_pf, err_isvf, err_vf}, {pf, vfa, vf});
      chk(err_hdr, hdr);
    end
    @(posedge mclk);
    #1;
    chk(flags, 7'h00);
    if (ok && lg) chk(u_bridge.logged_hdr, hdr);
  endtask : report

  task automatic step(input logic [3:0] iss, cmp, exp);
    @(posedge mclk);
    np_issue    <= iss;
    np_complete <= cmp;
    #1;
    chk(outstanding, exp);
    chk(rdy, 1'b1);
  endtask : step

  task automatic update(input logic v, input logic [1:0] pf, input logic [VF_OFS_W-1:0] vf,
                        input logic [7:0] dly);
    int n;
    n = 0;
    @(posedge mclk);
    ack_dly   <= dly;
    upd_valid <= 1'b1;
    upd_value <= v;
    upd_pf    <= pf;
    upd_vf    <= vf;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (req !== 1'b1 && n < 20);
    // Released user inputs are turned over so that stale data cannot pass.
    @(posedge mclk);
    upd_valid <= 1'b0;
    upd_value <= ~v;
    upd_pf    <= ~pf;
    upd_vf    <= ~vf;
    #1;
    while (ack !== 1'b1 && n < 60) begin
      chk({req, rdy, pend_val, pend_pf, pend_vf}, {1'b1, 1'b0, v, pf, vf});
      @(posedge mclk);
      #1;
      n++;
    end
    @(posedge mclk);
    #1;
    chk(n < 60, 1'b1);
    chk({req, ack, done}, 3'h1);
    chk(u_bridge.pend_tab[pf][vf], v);
  endtask : update

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    report(1'b1, 1'b0, 1'b1, 1'b0, 2'h1, 11'h000);
    report(1'b0, 1'b1, 1'b0, 1'b1, 2'h2, 11'h007);
    report(1'b1, 1'b1, 1'b1, 1'b1, 2'h3, 11'h000);
    report(1'b0, 1'b0, 1'b1, 1'b0, 2'h0, 11'h000);
    report(1'b1, 1'b0, 1'b1, 1'b1, 2'h1, 11'h008);
    step(4'hD, 4'h0, 4'h0);
    step(4'h1, 4'h1, 4'hD);
    step(4'h0, 4'h5, 4'hD);
    step(4'h0, 4'h8, 4'h8);
    step(4'h0, 4'h0, 4'h0);
    update(1'b1, 2'h2, 11'h007, 8'h00);
    update(1'b0, 2'h2, 11'h007, 8'h05);
    update(1'b1, 2'h3, 11'h004, 8'h01);
    chk(u_bridge.n_ur_posted, 2);
    chk(u_bridge.n_ur_np, 2);
    close_out();
  end

  initial begin
    repeat (5000) @(posedge mclk);
    n_errors++;
    close_out();
  end
endmodule : tb_scer_ctrl
